// ---- pkg/lcd_layer_consts.vh ----
// constants for the layer, scroll and cursor configuration block
`ifndef LCD_LAYER_CONSTS_VH
`define LCD_LAYER_CONSTS_VH

// ==========================================================
// direct register offsets
`define REG_BASE 16'h800b
`define REG_BLOCK1_START_LO 16'h800b
`define REG_BLOCK1_START_HI 16'h800c
`define REG_BLOCK1_LINES 16'h800d
`define REG_BLOCK2_START_LO 16'h800e
`define REG_BLOCK2_START_HI 16'h800f
`define REG_BLOCK2_LINES 16'h8010
`define REG_BLOCK3_START_LO 16'h8011
`define REG_BLOCK3_START_HI 16'h8012
`define REG_BLOCK4_START_LO 16'h8013
`define REG_BLOCK4_START_HI 16'h8014
`define REG_CURSOR_WIDTH 16'h8015
`define REG_CURSOR_HEIGHT_SHAPE 16'h8016
`define REG_CURSOR_STEP_DIR 16'h8017
`define REG_LAYER_COMPOSITION 16'h8018
`define REG_COUNT 14

// ==========================================================
// register indices (offset minus base)
`define IDX_B1_LO 4'd0
`define IDX_B1_HI 4'd1
`define IDX_B1_LINES 4'd2
`define IDX_B2_LO 4'd3
`define IDX_B2_HI 4'd4
`define IDX_B2_LINES 4'd5
`define IDX_B3_LO 4'd6
`define IDX_B3_HI 4'd7
`define IDX_B4_LO 4'd8
`define IDX_B4_HI 4'd9
`define IDX_CSR_W 4'd10
`define IDX_CSR_H 4'd11
`define IDX_STEP 4'd12
`define IDX_COMPOSE 4'd13

// ==========================================================
// field positions and writable masks
`define CSR_SHAPE_BIT 7
`define LAYER_COUNT_BIT 4
`define THIRD_MODE_BIT 3
`define FIRST_MODE_BIT 2
`define MASK_CSR_W 8'h0f
`define MASK_CSR_H 8'h8f
`define MASK_STEP 8'h03
`define MASK_COMPOSE 8'h1f
`define MASK_FULL 8'hff

// ==========================================================
// reset values
`define RESET_REG 8'h00
`define RESET_CURSOR 16'h0000

// ==========================================================
// command codes and parameter counts
`define CMD_SCROLL 8'h44
`define CMD_CURSOR_SHAPE 8'h5d
`define CMD_COMPOSE 8'h5b
`define CMD_STEP_TOP 6'h13
`define SCROLL_PARAMS 4'd10
`define CURSOR_SHAPE_PARAMS 4'd2
`define COMPOSE_PARAMS 4'd1

// ==========================================================
// step directions and composition methods
`define STEP_RIGHT 2'b00
`define STEP_LEFT 2'b01
`define STEP_UP 2'b10
`define STEP_DOWN 2'b11
`define MIX_OR 2'b00
`define MIX_XOR 2'b01
`define MIX_AND 2'b10
`define MIX_PRIO 2'b11

`endif

// ---- verification/lcd_config_monitor.sv ----
// checker for the layer, scroll and cursor configuration block
`timescale 1ns/10ps
module lcd_config_monitor
(
    // clock and reset
    input wire clk_i,
    input wire resetn_i,
    // direct bus
    input wire dir_wr_i,
    input wire dir_rd_i,
    input wire [15:0] dir_addr_i,
    input wire [7:0] dir_wdata_i,
    input wire dir_hit_o,
    input wire [7:0] dir_rdata_o,
    // cursor
    input wire csr_load_i,
    input wire mem_access_i,
    input wire [15:0] address_pitch_i,
    input wire [15:0] cursor_addr_o,
    input wire [1:0] step_dir_o,
    // blocks and layers
    input wire [8:0] block1_lines_o,
    input wire [8:0] block2_lines_o,
    input wire third_after_second_o,
    input wire layer_count_select_o,
    input wire [1:0] compose_method_o,
    input wire [2:0] layer_px_i,
    input wire pixel_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    // ==========================================================
    // register access
    unmapped_read_a: assert property (
        dir_rd_i && !dir_hit_o |=> dir_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    hit_decode_a: assert property (
        dir_hit_o == (dir_addr_i >= 16'h800b && dir_addr_i <= 16'h8018))
        else $error("address decode wrong");
    line_write_a: assert property (
        dir_wr_i && dir_addr_i == 16'h800d
        |=> block1_lines_o == {1'b0, $past(dir_wdata_i)} + 9'd1)
        else $error("line count not code plus one");
    third_place_a: assert property (
        third_after_second_o == (block2_lines_o < block1_lines_o))
        else $error("third block placed wrong");

    // ==========================================================
    // cursor stepping
    step_horiz_a: assert property (
        mem_access_i && !csr_load_i && !step_dir_o[1]
        |=> cursor_addr_o == ($past(step_dir_o[0]) ?
            $past(cursor_addr_o) - 16'h0001 :
            $past(cursor_addr_o) + 16'h0001))
        else $error("horizontal step wrong");
    step_vert_a: assert property (
        mem_access_i && !csr_load_i && step_dir_o[1]
        |=> cursor_addr_o == ($past(step_dir_o[0]) ?
            $past(cursor_addr_o) + $past(address_pitch_i) :
            $past(cursor_addr_o) - $past(address_pitch_i)))
        else $error("vertical step wrong");

    // ==========================================================
    // composition; two-layer l3 gating left to the bench
    pixel_or_a: assert property (
        compose_method_o == 2'b00 && layer_count_select_o
        |=> pixel_o == |$past(layer_px_i))
        else $error("or composition wrong");
    pixel_xor_a: assert property (
        compose_method_o == 2'b01 && layer_count_select_o
        |=> pixel_o == (($past(layer_px_i[0]) ^ $past(layer_px_i[1]))
            | $past(layer_px_i[2])))
        else $error("xor composition wrong");

    cover property (dir_rd_i && !dir_hit_o);
    cover property (mem_access_i && step_dir_o == 2'b11);
    cover property (compose_method_o == 2'b01 && pixel_o);
endmodule // lcd_config_monitor

// ---- verification/lcd_host_model.sv ----
// host model driving direct and indirect register accesses
`timescale 1ns/10ps
module lcd_host_model
(
    // clock
    input wire clk_i,
    // direct access
    output reg dir_wr_o,
    output reg dir_rd_o,
    output reg [15:0] dir_addr_o,
    output reg [7:0] dir_wdata_o,
    // indirect access
    output reg cmd_wr_o,
    output reg par_wr_o,
    output reg [7:0] bus_data_o
);
    initial
    begin
        {dir_wr_o, dir_rd_o, cmd_wr_o, par_wr_o} = 4'h0;
        dir_addr_o = 16'h0000;
        dir_wdata_o = 8'h00;
        bus_data_o = 8'h00;
    end

    // ==========================================================
    // one access per task; data inverted once released
    task wr(input [15:0] a, input [7:0] d);
    begin
        @(posedge clk_i);
        dir_wr_o <= 1'b1;
        dir_addr_o <= a;
        dir_wdata_o <= d;
        @(posedge clk_i);
        dir_wr_o <= 1'b0;
        dir_wdata_o <= ~d;
        #1;
    end
    endtask

    task rd(input [15:0] a);
    begin
        @(posedge clk_i);
        dir_rd_o <= 1'b1;
        dir_addr_o <= a;
        @(posedge clk_i);
        dir_rd_o <= 1'b0;
        #1;
    end
    endtask

    // commands first, then parameters in order from the first
    task put(input is_cmd, input [7:0] d);
    begin
        @(posedge clk_i);
        cmd_wr_o <= is_cmd;
        par_wr_o <= !is_cmd;
        bus_data_o <= d;
        @(posedge clk_i);
        {cmd_wr_o, par_wr_o} <= 2'b00;
        bus_data_o <= ~d;
        #1;
    end
    endtask
endmodule // lcd_host_model

// ---- verification/tb.sv ----
// self-checking bench for the configuration block
`timescale 1ns/10ps
module tb;
    reg clk_i, resetn_i, dual_panel_i, csr_load_i, mem_access_i;
    reg [7:0] lines_per_frame_i;
    reg [3:0] char_field_height_i;
    reg [15:0] address_pitch_i, csr_load_addr_i;
    reg [2:0] layer_px_i;
    wire dir_wr_i, dir_rd_i, cmd_wr_i, par_wr_i, dir_hit_o, pixel_o;
    wire [15:0] dir_addr_i, cursor_addr_o, b1s, b2s, b3s, b4s;
    wire [7:0] dir_wdata_i, bus_data_i, dir_rdata_o;
    wire [8:0] l1, l2, lower, bl1, bl2;
    wire [4:0] cw, ch;
    wire [1:0] step_dir_o, compose_method_o, src;
    wire b4u, third_after_second_o, shp, layer_count_select_o, fm, tm;
    integer bad_count = 0, check_count = 0, cycles = 0, i, v;
    reg [15:0] step_exp [0:3];

    lcd_host_model host (.clk_i(clk_i), .dir_wr_o(dir_wr_i),
        .dir_rd_o(dir_rd_i), .dir_addr_o(dir_addr_i),
        .dir_wdata_o(dir_wdata_i), .cmd_wr_o(cmd_wr_i),
        .par_wr_o(par_wr_i), .bus_data_o(bus_data_i));

    lcd_layer_scroll_cursor_config dut (.clk_i(clk_i),
        .resetn_i(resetn_i), .dir_wr_i(dir_wr_i), .dir_rd_i(dir_rd_i),
        .dir_addr_i(dir_addr_i), .dir_wdata_i(dir_wdata_i),
        .dir_hit_o(dir_hit_o), .dir_rdata_o(dir_rdata_o),
        .cmd_wr_i(cmd_wr_i), .par_wr_i(par_wr_i), .bus_data_i(bus_data_i),
        .dual_panel_i(dual_panel_i), .lines_per_frame_i(lines_per_frame_i),
        .char_field_height_i(char_field_height_i),
        .address_pitch_i(address_pitch_i), .csr_load_i(csr_load_i),
        .csr_load_addr_i(csr_load_addr_i), .mem_access_i(mem_access_i),
        .cursor_addr_o(cursor_addr_o), .block1_start_o(b1s),
        .block2_start_o(b2s), .block3_start_o(b3s), .block4_start_o(b4s),
        .block4_used_o(b4u), .block1_lines_o(l1), .block2_lines_o(l2),
        .lower_lines_o(lower), .third_after_second_o(third_after_second_o),
        .blank1_o(bl1), .blank2_o(bl2), .cursor_width_dots_o(cw),
        .cursor_height_dots_o(ch), .cursor_shape_o(shp),
        .step_dir_o(step_dir_o), .layer_count_select_o(layer_count_select_o),
        .first_block_mode_o(fm), .third_block_mode_o(tm),
        .compose_method_o(compose_method_o), .layer_px_i(layer_px_i),
        .pixel_o(pixel_o), .pixel_src_o(src));

    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    task chk(input string n, input [15:0] s, input [15:0] e);
    begin
        check_count++;
        if (s !== e)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    end
    endtask

    task stop_test;
    begin
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end
    endtask

    // a few thousand cycles is ample for this sequence
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            bad_count++;
            stop_test;
        end
    end

    function [7:0] msk(input integer k);
        msk = k == 10 ? 8'h0f : k == 11 ? 8'h8f : k == 12 ? 8'h03 :
            k == 13 ? 8'h1f : 8'hff;
    endfunction

    function pix(input [1:0] m, input [2:0] p);
        pix = m == 2'b01 ? (p[0] ^ p[1]) | p[2] :
            m == 2'b10 ? (p[0] & p[1]) | p[2] : |p;
    endfunction

    initial
    begin
        {resetn_i, dual_panel_i, csr_load_i, mem_access_i} = 4'h0;
        lines_per_frame_i = 8'h00;
        char_field_height_i = 4'h9;
        address_pitch_i = 16'h0050;
        csr_load_addr_i = 16'h0000;
        layer_px_i = 3'h0;
        step_exp[0] = 16'h0101;
        step_exp[1] = 16'h00ff;
        step_exp[2] = 16'h00b0;
        step_exp[3] = 16'h0150;
        repeat (20) @(posedge clk_i);
        resetn_i <= 1'b1;
        for (i = 0; i < 14; i++)
        begin
            host.rd(16'h800b + i);
            chk("reset", dir_rdata_o, 16'h0000);
            host.wr(16'h800b + i, 8'hff);
            host.rd(16'h800b + i);
            chk("mask", dir_rdata_o, msk(i));
        end
        host.rd(16'h8019);
        chk("unmapped", dir_rdata_o, 16'h0000);
        $display("test registers done");

        host.wr(16'h800d, 8'h00);
        chk("lines1 min", l1, 16'd1);
        host.wr(16'h800d, 8'hff);
        chk("lines1 max", l1, 16'd256);
        host.wr(16'h8010, 8'h10);
        chk("lines2", l2, 16'd17);
        chk("third under 2", third_after_second_o, 16'h1);
        host.wr(16'h8010, 8'hff);
        chk("third tie", third_after_second_o, 16'h0);
        @(posedge clk_i);
        dual_panel_i <= 1'b1;
        lines_per_frame_i <= 8'h7f;
        host.wr(16'h800d, 8'h3f);
        host.wr(16'h8010, 8'h1f);
        chk("lower lines", lower, 16'd64);
        chk("blank1", bl1, 16'd0);
        chk("blank2", bl2, 16'd32);
        chk("block4 used", b4u, 16'h1);
        host.wr(16'h8014, 8'h43);
        @(posedge clk_i);
        dual_panel_i <= 1'b0;
        host.wr(16'h8011, 8'h21);
        chk("lower single", lower, 16'd96);
        chk("blank2 single", bl2, 16'd0);
        chk("start3", b3s, 16'hff21);
        chk("start4", b4s, 16'h43ff);
        $display("test screen blocks done");

        host.put(1'b1, 8'h44);
        host.put(1'b0, 8'h12);
        host.put(1'b0, 8'h34);
        host.put(1'b0, 8'h56);
        host.put(1'b1, 8'h00);
        chk("start1", b1s, 16'h3412);
        chk("lines1 cmd", l1, 16'h0057);
        chk("start2 kept", b2s, 16'hffff);
        host.wr(16'h8018, 8'h00);
        host.put(1'b1, 8'h5d);
        host.put(1'b0, 8'h04);
        host.put(1'b0, 8'h85);
        host.put(1'b0, 8'h33);
        chk("width", cw, 16'd5);
        chk("shape", shp, 16'h1);
        chk("height text", ch, 16'd10);
        @(posedge clk_i);
        char_field_height_i <= 4'h2;
        @(posedge clk_i);
        #1;
        chk("height", ch, 16'd6);
        $display("test cursor form done");

        for (i = 0; i < 4; i++)
        begin
            host.put(1'b1, 8'h4c + i);
            chk("step dir", step_dir_o, i);
            @(posedge clk_i);
            csr_load_i <= 1'b1;
            csr_load_addr_i <= 16'h0100;
            @(posedge clk_i);
            csr_load_i <= 1'b0;
            mem_access_i <= 1'b1;
            @(posedge clk_i);
            mem_access_i <= 1'b0;
            #1;
            chk("cursor", cursor_addr_o, step_exp[i]);
        end
        $display("test cursor step done");

        for (i = 0; i < 4; i++)
        begin
            host.put(1'b1, 8'h5b);
            host.put(1'b0, 8'h1c | i);
            chk("compose", {layer_count_select_o, tm, fm, compose_method_o},
                {3'b111, i[1:0]});
            for (v = 0; v < 8; v++)
            begin
                @(posedge clk_i);
                layer_px_i <= v;
                @(posedge clk_i);
                #1;
                chk("pixel", pixel_o, pix(i, v));
                if (i == 3)
                    chk("source", src, v[0] ? 1 : v[1] ? 2 : v[2] ? 3 : 0);
            end
        end
        host.put(1'b1, 8'h5b);
        host.put(1'b0, 8'h03);
        @(posedge clk_i);
        layer_px_i <= 3'b100;
        @(posedge clk_i);
        #1;
        chk("two layer", {src, pixel_o}, 16'h0000);
        $display("test composition done");
        stop_test;
    end
endmodule // tb

bind lcd_layer_scroll_cursor_config lcd_config_monitor mon (
    .clk_i(clk_i), .resetn_i(resetn_i), .dir_wr_i(dir_wr_i),
    .dir_rd_i(dir_rd_i), .dir_addr_i(dir_addr_i),
    .dir_wdata_i(dir_wdata_i), .dir_hit_o(dir_hit_o),
    .dir_rdata_o(dir_rdata_o), .csr_load_i(csr_load_i),
    .mem_access_i(mem_access_i), .address_pitch_i(address_pitch_i),
    .cursor_addr_o(cursor_addr_o), .step_dir_o(step_dir_o),
    .block1_lines_o(block1_lines_o), .block2_lines_o(block2_lines_o),
    .third_after_second_o(third_after_second_o),
    .layer_count_select_o(layer_count_select_o),
    .compose_method_o(compose_method_o), .layer_px_i(layer_px_i),
    .pixel_o(pixel_o));

// ---- verilog/lcd_block_lines.v ----
// screen block line counts, split placement and dual-panel blanking
`timescale 1ns/10ps
`include "lcd_layer_consts.vh"

module lcd_block_lines
(
    // programmed values
    input wire [7:0] sl1_code_i,
    input wire [7:0] sl2_code_i,
    input wire [7:0] lf_code_i,
    input wire dual_i,
    // decoded counts
    output wire [8:0] block1_lines_o,
    output wire [8:0] block2_lines_o,
    output wire [8:0] lower_lines_o,
    output wire third_after_second_o,
    output wire [8:0] blank1_o,
    output wire [8:0] blank2_o
);

// ==========================================================
// decode
wire [8:0] lines1 = {1'b0, sl1_code_i} + 9'h001;
wire [8:0] lines2 = {1'b0, sl2_code_i} + 9'h001;
wire [8:0] frame = {1'b0, lf_code_i} + 9'h001;
wire [8:0] half = {1'b0, frame[8:1]};
wire second_smaller = lines2 < lines1;
wire [8:0] smaller = second_smaller ? lines2 : lines1;

assign block1_lines_o = lines1;
assign block2_lines_o = lines2;
// single panel: third block fills what the smaller upper block leaves
assign third_after_second_o = second_smaller;
assign lower_lines_o = dual_i ? half : (frame - smaller);
// only shortfall against the half frame can be blanked
assign blank1_o = (dual_i && lines1 < half) ? half - lines1 : 9'h000;
assign blank2_o = (dual_i && lines2 < half) ? half - lines2 : 9'h000;

endmodule // lcd_block_lines

// ---- verilog/lcd_cursor_stepper.v ----
// cursor address register with automatic stepping after each access
`timescale 1ns/10ps
`include "lcd_layer_consts.vh"

module lcd_cursor_stepper
(
    // clock and reset
    input wire clk_i,
    input wire resetn_i,
    // control
    input wire load_i,
    input wire [15:0] load_addr_i,
    input wire access_i,
    input wire [1:0] dir_i,
    input wire [15:0] pitch_i,
    // state
    output wire [15:0] addr_o
);

reg [15:0] addr_q;
reg [15:0] addr_d;

// ==========================================================
// step
always @*
begin
    addr_d = addr_q;
    if (load_i)
    begin
        addr_d = load_addr_i;
    end
    else if (access_i)
    begin
        // steps are in memory words, not characters
        case (dir_i)
            `STEP_RIGHT: addr_d = addr_q + 16'h0001;
            `STEP_LEFT: addr_d = addr_q - 16'h0001;
            `STEP_UP: addr_d = addr_q - pitch_i;
            `STEP_DOWN: addr_d = addr_q + pitch_i;
            default: addr_d = addr_q;
        endcase
    end
end

always @(posedge clk_i)
begin
    if (!resetn_i)
    begin
        addr_q <= `RESET_CURSOR;
    end
    else
    begin
        addr_q <= addr_d;
    end
end

assign addr_o = addr_q;

endmodule // lcd_cursor_stepper

// ---- verilog/lcd_layer_scroll_cursor_config.v ----
// layer, scroll block and cursor configuration registers with decode
//
// Summary of operation
// - block one start and line count registers
// - block two start and line count registers
// - block three start address, no count
// - line count decodes as code plus one
// - block three follows smaller upper block
// - dual panel lower counts from frame lines
// - dual panel blanks shortfall against half frame
// - cursor width is code plus one dots
// - cursor height code plus one, zero illegal
// - shape bit picks underline or block
// - text block cursor at least field height
// - two-bit step direction right left up down
// - horizontal steps move address by one
// - vertical steps move address by pitch
// - composition register field layout
// - one composition method for the whole screen
// - truncated parameter sequences are accepted
// - composition methods or, xor, and, priority
// - mode bits text zero, graphic one
// - layer count bit two or three layers
`timescale 1ns/10ps
`include "lcd_layer_consts.vh"

module lcd_layer_scroll_cursor_config
(
    // clock and reset
    input wire clk_i,
    input wire resetn_i,
    // direct register access
    input wire dir_wr_i,
    input wire dir_rd_i,
    input wire [15:0] dir_addr_i,
    input wire [7:0] dir_wdata_i,
    output wire dir_hit_o,
    output wire [7:0] dir_rdata_o,
    // indirect command and parameter access
    input wire cmd_wr_i,
    input wire par_wr_i,
    input wire [7:0] bus_data_i,
    // settings from the system setup logic
    input wire dual_panel_i,
    input wire [7:0] lines_per_frame_i,
    input wire [3:0] char_field_height_i,
    input wire [15:0] address_pitch_i,
    // cursor address control
    input wire csr_load_i,
    input wire [15:0] csr_load_addr_i,
    input wire mem_access_i,
    output wire [15:0] cursor_addr_o,
    // screen blocks
    output wire [15:0] block1_start_o,
    output wire [15:0] block2_start_o,
    output wire [15:0] block3_start_o,
    output wire [15:0] block4_start_o,
    output wire block4_used_o,
    output wire [8:0] block1_lines_o,
    output wire [8:0] block2_lines_o,
    output wire [8:0] lower_lines_o,
    output wire third_after_second_o,
    output wire [8:0] blank1_o,
    output wire [8:0] blank2_o,
    // cursor form
    output wire [4:0] cursor_width_dots_o,
    output wire [4:0] cursor_height_dots_o,
    output wire cursor_shape_o,
    output wire [1:0] step_dir_o,
    // layer composition
    output wire layer_count_select_o,
    output wire first_block_mode_o,
    output wire third_block_mode_o,
    output wire [1:0] compose_method_o,
    input wire [2:0] layer_px_i,
    output wire pixel_o,
    output wire [1:0] pixel_src_o
);

// ==========================================================
// register storage
reg [7:0] regs_q [0:`REG_COUNT-1];
reg [7:0] dir_rdata_q;
reg pixel_q;
reg [1:0] pixel_src_q;

// ==========================================================
// indirect parameter sequencer
reg seq_active_q;
reg [3:0] seq_base_q;
reg [3:0] seq_cnt_q;
reg [3:0] seq_max_q;

wire step_cmd = cmd_wr_i && (bus_data_i[7:2] == `CMD_STEP_TOP);
// parameters past the command's own count are ignored
wire par_ok = par_wr_i && seq_active_q && (seq_cnt_q < seq_max_q);
wire [3:0] par_idx = seq_base_q + seq_cnt_q;

always @(posedge clk_i)
begin
    if (!resetn_i)
    begin
        seq_active_q <= 1'b0;
        seq_base_q <= 4'h0;
        seq_cnt_q <= 4'h0;
        seq_max_q <= 4'h0;
    end
    else if (cmd_wr_i)
    begin
        // a new command ends any earlier sequence, so a short one stands
        seq_cnt_q <= 4'h0;
        case (bus_data_i)
            `CMD_SCROLL:
            begin
                seq_active_q <= 1'b1;
                seq_base_q <= `IDX_B1_LO;
                seq_max_q <= `SCROLL_PARAMS;
            end
            `CMD_CURSOR_SHAPE:
            begin
                seq_active_q <= 1'b1;
                seq_base_q <= `IDX_CSR_W;
                seq_max_q <= `CURSOR_SHAPE_PARAMS;
            end
            `CMD_COMPOSE:
            begin
                seq_active_q <= 1'b1;
                seq_base_q <= `IDX_COMPOSE;
                seq_max_q <= `COMPOSE_PARAMS;
            end
            default:
            begin
                seq_active_q <= 1'b0;
                seq_base_q <= 4'h0;
                seq_max_q <= 4'h0;
            end
        endcase
    end
    else if (par_ok)
    begin
        seq_cnt_q <= seq_cnt_q + 4'h1;
    end
end

// ==========================================================
// direct decode
wire [15:0] dir_off = dir_addr_i - `REG_BASE;
wire dir_hit = (dir_addr_i >= `REG_BASE) &&
    (dir_off < `REG_COUNT);
wire [3:0] dir_idx = dir_off[3:0];

assign dir_hit_o = dir_hit;

// reserved bits are never stored, so they read back as zero
function [7:0] reg_mask;
    input [3:0] idx;
    begin
        case (idx)
            `IDX_CSR_W: reg_mask = `MASK_CSR_W;
            `IDX_CSR_H: reg_mask = `MASK_CSR_H;
            `IDX_STEP: reg_mask = `MASK_STEP;
            `IDX_COMPOSE: reg_mask = `MASK_COMPOSE;
            default: reg_mask = `MASK_FULL;
        endcase
    end
endfunction

// ==========================================================
// per-register write
genvar e;
generate
    for (e = 0; e < `REG_COUNT; e = e + 1)
    begin : g_reg
        localparam [3:0] slot_idx = e;
        wire dir_we = dir_wr_i && dir_hit && (dir_idx == slot_idx);
        wire par_we = par_ok && (par_idx == slot_idx);
        wire cmd_we = step_cmd && (slot_idx == `IDX_STEP);
        reg [7:0] wval;
        always @*
        begin
            // direct access wins over a same-cycle indirect write
            if (dir_we)
            begin
                wval = dir_wdata_i;
            end
            else if (cmd_we)
            begin
                wval = {6'h00, bus_data_i[1:0]};
            end
            else
            begin
                wval = bus_data_i;
            end
        end
        always @(posedge clk_i)
        begin
            if (!resetn_i)
            begin
                regs_q[e] <= `RESET_REG;
            end
            else if (dir_we || par_we || cmd_we)
            begin
                regs_q[e] <= wval & reg_mask(slot_idx);
            end
        end
    end
endgenerate

// ==========================================================
// read back
always @(posedge clk_i)
begin
    if (!resetn_i)
    begin
        dir_rdata_q <= 8'h00;
    end
    else if (dir_rd_i)
    begin
        dir_rdata_q <= dir_hit ? regs_q[dir_idx] : 8'h00;
    end
end

assign dir_rdata_o = dir_rdata_q;

// ==========================================================
// screen blocks
assign block1_start_o = {regs_q[`IDX_B1_HI], regs_q[`IDX_B1_LO]};
assign block2_start_o = {regs_q[`IDX_B2_HI], regs_q[`IDX_B2_LO]};
assign block3_start_o = {regs_q[`IDX_B3_HI], regs_q[`IDX_B3_LO]};
assign block4_start_o = {regs_q[`IDX_B4_HI], regs_q[`IDX_B4_LO]};

wire layer3 = regs_q[`IDX_COMPOSE][`LAYER_COUNT_BIT];
wire first_gfx = regs_q[`IDX_COMPOSE][`FIRST_MODE_BIT];
wire third_gfx = regs_q[`IDX_COMPOSE][`THIRD_MODE_BIT];
// dual panel alone selects block four beside block three; the layer count bit is not forced
assign block4_used_o = dual_panel_i;

lcd_block_lines u_lines
(
    .sl1_code_i(regs_q[`IDX_B1_LINES]),
    .sl2_code_i(regs_q[`IDX_B2_LINES]),
    .lf_code_i(lines_per_frame_i),
    .dual_i(dual_panel_i),
    .block1_lines_o(block1_lines_o),
    .block2_lines_o(block2_lines_o),
    .lower_lines_o(lower_lines_o),
    .third_after_second_o(third_after_second_o),
    .blank1_o(blank1_o),
    .blank2_o(blank2_o)
);

// ==========================================================
// cursor form
wire [4:0] cursor_width_dots = {1'b0, regs_q[`IDX_CSR_W][3:0]} + 5'h01;
wire [4:0] cursor_height_dots = {1'b0, regs_q[`IDX_CSR_H][3:0]} + 5'h01;
wire [4:0] fy = {1'b0, char_field_height_i} + 5'h01;
wire shape = regs_q[`IDX_CSR_H][`CSR_SHAPE_BIT];
// block cursor on a text screen covers the full field at least
wire stretch = shape && !first_gfx && (cursor_height_dots < fy);

assign cursor_width_dots_o = cursor_width_dots;
assign cursor_height_dots_o = stretch ? fy : cursor_height_dots;
assign cursor_shape_o = shape;
assign step_dir_o = regs_q[`IDX_STEP][1:0];

lcd_cursor_stepper u_cursor
(
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .load_i(csr_load_i),
    .load_addr_i(csr_load_addr_i),
    .access_i(mem_access_i),
    .dir_i(regs_q[`IDX_STEP][1:0]),
    .pitch_i(address_pitch_i),
    .addr_o(cursor_addr_o)
);

// ==========================================================
// layer composition
assign layer_count_select_o = layer3;
assign first_block_mode_o = first_gfx;
assign third_block_mode_o = third_gfx;
assign compose_method_o = regs_q[`IDX_COMPOSE][1:0];

// third layer only exists in three-layer composition
wire l1 = layer_px_i[0];
wire l2 = layer_px_i[1];
wire l3 = layer_px_i[2] && layer3;

// one method for the whole screen; no per-block override exists
always @(posedge clk_i)
begin
    if (!resetn_i)
    begin
        pixel_q <= 1'b0;
        pixel_src_q <= 2'b00;
    end
    else
    begin
        case (regs_q[`IDX_COMPOSE][1:0])
            `MIX_OR: pixel_q <= l1 | l2 | l3;
            `MIX_XOR: pixel_q <= (l1 ^ l2) | l3;
            `MIX_AND: pixel_q <= (l1 & l2) | l3;
            `MIX_PRIO: pixel_q <= l1 | l2 | l3;
            default: pixel_q <= 1'b0;
        endcase
        // source layer for the priority overlay: lowest number wins
        if (l1)
        begin
            pixel_src_q <= 2'b01;
        end
        else if (l2)
        begin
            pixel_src_q <= 2'b10;
        end
        else if (l3)
        begin
            pixel_src_q <= 2'b11;
        end
        else
        begin
            pixel_src_q <= 2'b00;
        end
    end
end

assign pixel_o = pixel_q;
assign pixel_src_o = pixel_src_q;

endmodule // lcd_layer_scroll_cursor_config
